// ==== dv/capture_count_and_idle_timer_bench.sv ====
`timescale 1ns/1ps
module capture_count_and_idle_timer_bench;
	import count_timer_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [UADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [DATA_W-1:0] rdata;
	logic irq;
	logic [DATA_W-1:0] d;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;
	count_timer_if link_if();
	count_timer_dev #(.SLOW_TICK_CYCLES(500)) count_timer_dev_inst (
		.clock_i(clock), .arst_n_i(arst_n), .link(link_if.dev));
	count_timer_host count_timer_host_inst (
		.clock_i(clock), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
		.link(link_if.host));
	count_timer_props count_timer_props_inst (
		.clock_i(clock), .arst_n_i(arst_n),
		.reg_index(link_if.reg_index), .reg_wdata(link_if.reg_wdata),
		.reg_wr(link_if.reg_wr), .reg_rd(link_if.reg_rd),
		.reg_rdata(link_if.reg_rdata), .dma_byte(link_if.dma_byte),
		.activity(link_if.activity), .capture_irq(link_if.capture_irq),
		.timer_irq(link_if.timer_irq));
	always #20 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			$display("unexpected at %0t ns: run timed out", $time);
			test_done();
		end
	end
	task automatic test_done;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [DATA_W-1:0] got, exp, input string m);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t ns: %s", $time, m);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic sw_wr(input logic [UADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// read data appear in the cycle after the strobe and hold until the next read
	task automatic sw_rd(input logic [UADDR_W-1:0] a,
		output logic [DATA_W-1:0] v);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic dev_wr(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] v);
		sw_wr(UREG_LINK_INDEX, {10'h000, i});
		sw_wr(UREG_LINK_DATA, v);
	endtask
	task automatic rd_chk(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] e,
		input string m);
		logic [DATA_W-1:0] v;
		sw_wr(UREG_LINK_INDEX, {10'h000, i});
		sw_wr(UREG_LINK_READ, 16'h0000);
		wait_cyc(4);
		sw_rd(UREG_LINK_DATA, v);
		chk(v, e, m);
	endtask
	task automatic reset_values;
		logic [IDX_W-1:0] idx [4];
		idx = '{IDX_CAPTURE_RELOAD, IDX_CAPTURE_REMAINING, IDX_TIMER_RELOAD,
			IDX_TIMER_REMAINING};
		foreach (idx[k]) rd_chk(idx[k], 16'h0000, "count not clear");
		dev_wr(6'h3f, 16'hffff);
		rd_chk(6'h3f, 16'h0000, "unmapped index not zero");
	endtask
	task automatic base_copies;
		dev_wr(IDX_CAPTURE_RELOAD, 16'h1234);
		rd_chk(IDX_CAPTURE_REMAINING, 16'h1234, "capture load");
		dev_wr(IDX_TIMER_RELOAD, 16'hbeef);
		rd_chk(IDX_TIMER_REMAINING, 16'hbeef, "timer load");
	endtask
	task automatic capture_wrap;
		dev_wr(IDX_CAPTURE_RELOAD, 16'h0001);
		sw_wr(UREG_MASK, 16'h0000);
		dev_wr(IDX_RUN_CTRL, 16'h0001);
		// seven bytes: one group, then three that must not wrap
		sw_wr(UREG_DMA_BURST, 16'h0007);
		wait_cyc(12);
		dev_wr(IDX_RUN_CTRL, 16'h0000);
		rd_chk(IDX_CAPTURE_REMAINING, 16'h0000, "capture step");
		// earlier link reads leave the sticky read-done bit set
		sw_rd(UREG_STATUS, d);
		chk(d, 16'h0004, "capture event before wrap");
		dev_wr(IDX_RUN_CTRL, 16'h0001);
		sw_wr(UREG_DMA_BURST, 16'h0004);
		wait_cyc(10);
		dev_wr(IDX_RUN_CTRL, 16'h0000);
		#1 chk(irq, 16'h0000, "masked interrupt seen");
		sw_wr(UREG_MASK, 16'h0001);
		#1 chk(irq, 16'h0001, "interrupt missing");
		sw_rd(UREG_STATUS, d);
		chk(d, 16'h0001, "capture status");
		chk(irq, 16'h0000, "interrupt not cleared");
		rd_chk(IDX_CAPTURE_REMAINING, 16'h0001, "capture reload");
	endtask
	task automatic timer_ticks;
		dev_wr(IDX_TIMER_RELOAD, 16'h0002);
		dev_wr(IDX_TIMER_CTRL, 16'h0000);
		sw_wr(UREG_MASK, 16'h0002);
		dev_wr(IDX_RUN_CTRL, 16'h0002);
		wait_cyc(600);
		dev_wr(IDX_RUN_CTRL, 16'h0000);
		rd_chk(IDX_TIMER_REMAINING, 16'h0000, "fast ticks");
		sw_rd(UREG_STATUS, d);
		chk(d, 16'h0004, "timer event too early");
		// a stale prescaler would tick inside this short run
		dev_wr(IDX_RUN_CTRL, 16'h0002);
		wait_cyc(230);
		dev_wr(IDX_RUN_CTRL, 16'h0000);
		rd_chk(IDX_TIMER_REMAINING, 16'h0000, "prescaler kept");
		dev_wr(IDX_RUN_CTRL, 16'h0002);
		wait_cyc(260);
		dev_wr(IDX_RUN_CTRL, 16'h0000);
		#1 chk(irq, 16'h0001, "timer interrupt missing");
		sw_rd(UREG_STATUS, d);
		chk(d, 16'h0006, "timer status");
		rd_chk(IDX_TIMER_REMAINING, 16'h0002, "timer reload");
		dev_wr(IDX_TIMER_CTRL, 16'h0100);
		dev_wr(IDX_RUN_CTRL, 16'h0002);
		wait_cyc(300);
		dev_wr(IDX_RUN_CTRL, 16'h0000);
		rd_chk(IDX_TIMER_REMAINING, 16'h0002, "slow tick early");
		dev_wr(IDX_RUN_CTRL, 16'h0002);
		wait_cyc(520);
		dev_wr(IDX_RUN_CTRL, 16'h0000);
		rd_chk(IDX_TIMER_REMAINING, 16'h0001, "slow tick");
	endtask
	task automatic activity_reload;
		dev_wr(IDX_TIMER_RELOAD, 16'h0003);
		dev_wr(IDX_TIMER_CTRL, 16'h0400);
		dev_wr(IDX_RUN_CTRL, 16'h0002);
		wait_cyc(600);
		sw_wr(UREG_ACTIVITY, 16'h0002);
		dev_wr(IDX_RUN_CTRL, 16'h0000);
		rd_chk(IDX_TIMER_REMAINING, 16'h0001, "disabled channel");
		dev_wr(IDX_RUN_CTRL, 16'h0002);
		sw_wr(UREG_ACTIVITY, 16'h0001);
		dev_wr(IDX_RUN_CTRL, 16'h0000);
		rd_chk(IDX_TIMER_REMAINING, 16'h0003, "activity reload");
	endtask
	initial begin
		repeat (12) @(posedge clock);
		arst_n <= 1'b1;
		reset_values();
		base_copies();
		capture_wrap();
		timer_ticks();
		activity_reload();
		test_done();
	end
endmodule

// ==== dv/count_timer_props.sv ====
`timescale 1ns/1ps
module count_timer_props (
	// clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// link signals
	input wire logic [count_timer_pkg::IDX_W-1:0] reg_index,
	input wire logic [count_timer_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [count_timer_pkg::DATA_W-1:0] reg_rdata,
	input wire logic dma_byte,
	input wire logic [count_timer_pkg::ACT_W-1:0] activity,
	input wire logic capture_irq,
	input wire logic timer_irq
);
	import count_timer_pkg::*;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	// a rising timer run restarts the prescaler, so track the run bit
	logic tmr_on_q;
	wire run_wr = reg_wr && reg_index == IDX_RUN_CTRL;
	wire run_up = run_wr && reg_wdata[RUN_TIMER_BIT] && !tmr_on_q;
	wire cap_wr = reg_wr && (reg_index == IDX_CAPTURE_RELOAD ||
		reg_index == IDX_CAPTURE_REMAINING);
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) tmr_on_q <= 1'b0;
		else if (run_wr) tmr_on_q <= reg_wdata[RUN_TIMER_BIT];
	end
	strobe_excl_a: assert property (!(reg_wr && reg_rd))
		else $error("link read and write strobes together");
	cap_spacing_a: assert property (capture_irq |=> !capture_irq [*3])
		else $error("capture events closer than one group");
	cap_cause_a: assert property (capture_irq |-> $past(dma_byte))
		else $error("capture event without a transfer");
	cap_wr_wins_a: assert property (cap_wr |=> !capture_irq)
		else $error("capture event beside a count load");
	tmr_spacing_a: assert property (timer_irq |=> !timer_irq [*8])
		else $error("timer events too close");
	run_quiet_a: assert property (run_up |=> !timer_irq [*8])
		else $error("timer event right after start");
	rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data moved without a read");
	unmapped_rd_a: assert property (reg_rd && reg_index == 6'h3f
		|=> reg_rdata == 16'h0000)
		else $error("unmapped index read not zero");
	cov_cap: cover property (capture_irq);
	cov_tmr: cover property (timer_irq);
	cov_unmapped: cover property (reg_rd && reg_index == 6'h3f);
endmodule

// ==== inc/count_timer_if.sv ====
`timescale 1ns/1ps
interface count_timer_if;
	import count_timer_pkg::*;

	// indexed register access, read data one cycle after the strobe
	logic [IDX_W-1:0] reg_index;
	logic [DATA_W-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	// one pulse per byte moved by capture dma
	logic dma_byte;
	// activity pulses for timer reload
	logic [ACT_W-1:0] activity;
	// one-cycle event pulses from the device
	logic capture_irq;
	logic timer_irq;

	modport dev (
		input reg_index,
		input reg_wdata,
		input reg_wr,
		input reg_rd,
		output reg_rdata,
		input dma_byte,
		input activity,
		output capture_irq,
		output timer_irq
	);

	modport host (
		output reg_index,
		output reg_wdata,
		output reg_wr,
		output reg_rd,
		input reg_rdata,
		output dma_byte,
		output activity,
		input capture_irq,
		input timer_irq
	);

endinterface

// ==== inc/count_timer_pkg.sv ====
package count_timer_pkg;

	// clock and tick timing
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned TICK_FAST_US = 10;
	localparam int unsigned TICK_SLOW_MS = 100;
	localparam int unsigned TICK_FAST_CYCLES = CLK_HZ / 1_000_000 * TICK_FAST_US;
	localparam int unsigned TICK_SLOW_CYCLES = CLK_HZ / 1_000 * TICK_SLOW_MS;
	localparam int unsigned PRESCALE_W = 22;

	// widths
	localparam int unsigned IDX_W = 6;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ACT_W = 5;
	localparam int unsigned BYTES_PER_GROUP = 4;

	// device indexed registers
	localparam logic [IDX_W-1:0] IDX_RUN_CTRL = 6'h01;
	localparam logic [IDX_W-1:0] IDX_CAPTURE_RELOAD = 6'h0a;
	localparam logic [IDX_W-1:0] IDX_CAPTURE_REMAINING = 6'h0b;
	localparam logic [IDX_W-1:0] IDX_TIMER_RELOAD = 6'h0c;
	localparam logic [IDX_W-1:0] IDX_TIMER_REMAINING = 6'h0d;
	localparam logic [IDX_W-1:0] IDX_TIMER_CTRL = 6'h2c;

	// run control fields
	localparam int unsigned RUN_CAPTURE_BIT = 0;
	localparam int unsigned RUN_TIMER_BIT = 1;
	// timer control fields
	localparam int unsigned TICK_SELECT_BIT = 8;
	localparam int unsigned RELOAD_EN_LSB = 10;

	localparam logic [DATA_W-1:0] COUNT_RESET = 16'h0000;

	// host user-side registers
	localparam int unsigned UADDR_W = 4;
	localparam logic [UADDR_W-1:0] UREG_LINK_INDEX = 4'h0;
	localparam logic [UADDR_W-1:0] UREG_LINK_DATA = 4'h1;
	localparam logic [UADDR_W-1:0] UREG_LINK_READ = 4'h2;
	localparam logic [UADDR_W-1:0] UREG_STATUS = 4'h3;
	localparam logic [UADDR_W-1:0] UREG_MASK = 4'h4;
	localparam logic [UADDR_W-1:0] UREG_DMA_BURST = 4'h5;
	localparam logic [UADDR_W-1:0] UREG_ACTIVITY = 4'h6;

	// status and mask fields
	localparam int unsigned ST_W = 3;
	localparam int unsigned ST_CAPTURE_BIT = 0;
	localparam int unsigned ST_TIMER_BIT = 1;
	localparam int unsigned ST_READ_DONE_BIT = 2;

endpackage

// ==== src/count_timer_dev.sv ====
`timescale 1ns/1ps
// How it works
// - capture base write also loads capture count
// - software loads capture base only when stopped
// - capture count drops once per four dma bytes
// - transfer at zero interrupts and reloads capture
// - capture base equals bytes/4 minus one
// - capture buffer length is multiple of four
// - capture count touched only while stopped
// - timer base write also loads timer count
// - software loads timer base only when stopped
// - tick is 10 us or 100 ms
// - timer count drops once per tick
// - tick at zero interrupts and reloads timer
// - timer count touched only while stopped
// - select one gives 100 ms, zero 10 us
// - enabled channel activity reloads timer count
module count_timer_dev #(
	parameter int unsigned SLOW_TICK_CYCLES =
		count_timer_pkg::TICK_SLOW_CYCLES
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// link to host and dma
	count_timer_if.dev link
);
	import count_timer_pkg::*;

	localparam logic [PRESCALE_W-1:0] FAST_LAST =
		PRESCALE_W'(TICK_FAST_CYCLES - 1);
	localparam logic [PRESCALE_W-1:0] SLOW_LAST =
		PRESCALE_W'(SLOW_TICK_CYCLES - 1);
	localparam logic [1:0] GROUP_LAST = 2'(BYTES_PER_GROUP - 1);

	// one step of a reloading down-counter: {wrapped, next value}
	function automatic logic [DATA_W:0] count_step(
		input logic [DATA_W-1:0] cur,
		input logic [DATA_W-1:0] base
	);
		if (cur == COUNT_RESET) begin
			count_step = {1'b1, base};
		end else begin
			count_step = {1'b0, cur - 16'h0001};
		end
	endfunction

	// registers
	logic [DATA_W-1:0] capture_reload_value_q;
	logic [DATA_W-1:0] capture_remaining_q, capture_remaining_d;
	logic [DATA_W-1:0] timer_reload_value_q;
	logic [DATA_W-1:0] timer_remaining_q, timer_remaining_d;
	logic capture_run_q;
	logic timer_run_q;
	logic tick_period_select_q;
	logic [ACT_W-1:0] reload_enable_q;
	logic [1:0] byte_count_q;
	logic [PRESCALE_W-1:0] prescale_q;
	logic [DATA_W-1:0] rdata_q;
	logic capture_irq_q, timer_irq_q;

	// address decode
	wire wr_run = link.reg_wr && link.reg_index == IDX_RUN_CTRL;
	wire wr_cap_base = link.reg_wr && link.reg_index == IDX_CAPTURE_RELOAD;
	wire wr_cap_cur = link.reg_wr && link.reg_index == IDX_CAPTURE_REMAINING;
	wire wr_tmr_base = link.reg_wr && link.reg_index == IDX_TIMER_RELOAD;
	wire wr_tmr_cur = link.reg_wr && link.reg_index == IDX_TIMER_REMAINING;
	wire wr_tmr_ctrl = link.reg_wr && link.reg_index == IDX_TIMER_CTRL;

	// capture group strobe: fourth byte of each group
	wire group_done = capture_run_q && link.dma_byte &&
		byte_count_q == GROUP_LAST;

	// tick prescaler
	wire run_rise = wr_run && link.reg_wdata[RUN_TIMER_BIT] && !timer_run_q;
	wire [PRESCALE_W-1:0] tick_last =
		tick_period_select_q ? SLOW_LAST : FAST_LAST;
	wire tick = timer_run_q && prescale_q == tick_last;

	wire [DATA_W:0] cap_step =
		count_step(capture_remaining_q, capture_reload_value_q);
	wire [DATA_W:0] tmr_step =
		count_step(timer_remaining_q, timer_reload_value_q);

	wire activity_hit = |(link.activity & reload_enable_q);

	// capture count next value; a register write outranks a transfer
	always_comb begin
		capture_remaining_d = capture_remaining_q;
		if (wr_cap_base || wr_cap_cur) begin
			capture_remaining_d = link.reg_wdata;
		end else if (group_done) begin
			capture_remaining_d = cap_step[DATA_W-1:0];
		end
	end

	// timer count next value: write, then activity, then tick
	always_comb begin
		timer_remaining_d = timer_remaining_q;
		if (wr_tmr_base || wr_tmr_cur) begin
			timer_remaining_d = link.reg_wdata;
		end else if (activity_hit) begin
			timer_remaining_d = timer_reload_value_q;
		end else if (tick) begin
			timer_remaining_d = tmr_step[DATA_W-1:0];
		end
	end

	// read mux, answered one cycle after the strobe
	logic [DATA_W-1:0] rmux;
	always_comb begin
		rmux = 16'h0000;
		case (link.reg_index)
			IDX_RUN_CTRL: begin
				rmux[RUN_CAPTURE_BIT] = capture_run_q;
				rmux[RUN_TIMER_BIT] = timer_run_q;
			end
			IDX_CAPTURE_RELOAD: rmux = capture_reload_value_q;
			IDX_CAPTURE_REMAINING: rmux = capture_remaining_q;
			IDX_TIMER_RELOAD: rmux = timer_reload_value_q;
			IDX_TIMER_REMAINING: rmux = timer_remaining_q;
			IDX_TIMER_CTRL: begin
				rmux[TICK_SELECT_BIT] = tick_period_select_q;
				rmux[RELOAD_EN_LSB +: ACT_W] = reload_enable_q;
			end
			default: rmux = 16'h0000;
		endcase
	end

	// counts and control, cleared at reset so nothing counts yet
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			capture_reload_value_q <= COUNT_RESET;
			capture_remaining_q <= COUNT_RESET;
			timer_reload_value_q <= COUNT_RESET;
			timer_remaining_q <= COUNT_RESET;
			capture_run_q <= 1'b0;
			timer_run_q <= 1'b0;
			tick_period_select_q <= 1'b0;
			reload_enable_q <= '0;
		end else begin
			capture_remaining_q <= capture_remaining_d;
			timer_remaining_q <= timer_remaining_d;
			if (wr_cap_base) begin
				capture_reload_value_q <= link.reg_wdata;
			end
			if (wr_tmr_base) begin
				timer_reload_value_q <= link.reg_wdata;
			end
			if (wr_run) begin
				capture_run_q <= link.reg_wdata[RUN_CAPTURE_BIT];
				timer_run_q <= link.reg_wdata[RUN_TIMER_BIT];
			end
			if (wr_tmr_ctrl) begin
				tick_period_select_q <= link.reg_wdata[TICK_SELECT_BIT];
				reload_enable_q <= link.reg_wdata[RELOAD_EN_LSB +: ACT_W];
			end
		end
	end

	// byte grouping; a stopped capture forgets a partial group so the
	// next start begins on a group boundary
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			byte_count_q <= 2'h0;
		end else if (!capture_run_q) begin
			byte_count_q <= 2'h0;
		end else if (link.dma_byte) begin
			byte_count_q <= byte_count_q + 2'h1;
		end
	end

	// free-running prescaler, held at zero while stopped
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prescale_q <= '0;
		end else if (run_rise || !timer_run_q || tick) begin
			prescale_q <= '0;
		end else begin
			prescale_q <= prescale_q + 1'b1;
		end
	end

	// event pulses and read data
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			capture_irq_q <= 1'b0;
			timer_irq_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			capture_irq_q <= group_done && !(wr_cap_base || wr_cap_cur) &&
				cap_step[DATA_W];
			timer_irq_q <= tick && !(wr_tmr_base || wr_tmr_cur) &&
				!activity_hit && tmr_step[DATA_W];
			if (link.reg_rd) begin
				rdata_q <= rmux;
			end
		end
	end

	assign link.reg_rdata = rdata_q;
	assign link.capture_irq = capture_irq_q;
	assign link.timer_irq = timer_irq_q;

endmodule

// ==== src/count_timer_host.sv ====
`timescale 1ns/1ps
module count_timer_host (
	// clock and reset
	input wire logic clock_i,
	input wire logic arst_n_i,
	// software port
	input wire logic [count_timer_pkg::UADDR_W-1:0] addr_i,
	input wire logic [count_timer_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [count_timer_pkg::DATA_W-1:0] rdata_o,
	output logic irq_o,
	// device link
	count_timer_if.host link
);
	import count_timer_pkg::*;

	logic [IDX_W-1:0] index_q;
	logic [DATA_W-1:0] rd_data_q;
	logic [ST_W-1:0] status_q, status_d;
	logic [ST_W-1:0] mask_q;
	logic [DATA_W-1:0] burst_q;
	logic read_pend_q;
	logic [DATA_W-1:0] rdata_q;
	logic [IDX_W-1:0] link_index_q;
	logic [DATA_W-1:0] link_wdata_q;
	logic link_wr_q, link_rd_q;
	logic [ACT_W-1:0] activity_q;

	wire wr_index = wr_i && addr_i == UREG_LINK_INDEX;
	wire wr_data = wr_i && addr_i == UREG_LINK_DATA;
	wire wr_read = wr_i && addr_i == UREG_LINK_READ;
	wire wr_mask = wr_i && addr_i == UREG_MASK;
	wire wr_burst = wr_i && addr_i == UREG_DMA_BURST;
	wire wr_act = wr_i && addr_i == UREG_ACTIVITY;
	wire rd_status = rd_i && addr_i == UREG_STATUS;
	wire burst_busy = burst_q != 16'h0000;

	wire [ST_W-1:0] events = {read_pend_q, link.timer_irq, link.capture_irq};

	// a new event in the clearing read survives it
	always_comb begin
		status_d = status_q;
		if (rd_status) begin
			status_d = '0;
		end
		status_d = status_d | events;
	end

	logic [DATA_W-1:0] rmux;
	always_comb begin
		case (addr_i)
			UREG_LINK_INDEX: rmux = {{(DATA_W-IDX_W){1'b0}}, index_q};
			UREG_LINK_DATA: rmux = rd_data_q;
			UREG_STATUS: rmux = {{(DATA_W-ST_W){1'b0}}, status_q};
			UREG_MASK: rmux = {{(DATA_W-ST_W){1'b0}}, mask_q};
			UREG_DMA_BURST: rmux = burst_q;
			default: rmux = 16'h0000;
		endcase
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			index_q <= '0;
			rd_data_q <= 16'h0000;
			status_q <= '0;
			mask_q <= '0;
			burst_q <= 16'h0000;
			read_pend_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			status_q <= status_d;
			read_pend_q <= link_rd_q;
			if (read_pend_q) begin
				rd_data_q <= link.reg_rdata;
			end
			if (wr_index) begin
				index_q <= wdata_i[IDX_W-1:0];
			end
			if (wr_mask) begin
				mask_q <= wdata_i[ST_W-1:0];
			end
			// each byte strobe is one byte of the four-byte group
			if (wr_burst) begin
				burst_q <= wdata_i;
			end else if (burst_busy) begin
				burst_q <= burst_q - 16'h0001;
			end
			if (rd_i) begin
				rdata_q <= rmux;
			end
		end
	end

	// link drivers registered so the device sees clean strobes
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			link_index_q <= '0;
			link_wdata_q <= 16'h0000;
			link_wr_q <= 1'b0;
			link_rd_q <= 1'b0;
			activity_q <= '0;
		end else begin
			link_wr_q <= wr_data;
			link_rd_q <= wr_read;
			activity_q <= wr_act ? wdata_i[ACT_W-1:0] : '0;
			if (wr_data || wr_read) begin
				link_index_q <= index_q;
			end
			if (wr_data) begin
				link_wdata_q <= wdata_i;
			end
		end
	end

	// software must stop a counter before loading or touching it
	// the base is set to bytes/4 minus one
	assign link.reg_index = link_index_q;
	assign link.reg_wdata = link_wdata_q;
	assign link.reg_wr = link_wr_q;
	assign link.reg_rd = link_rd_q;
	assign link.dma_byte = burst_busy;
	assign link.activity = activity_q;

	assign rdata_o = rdata_q;
	assign irq_o = |(status_q & mask_q);

endmodule
